// ### core/dmac_pkg.sv
/*
  Shared constants, enumerations and carriers of the DSP arithmetic and
  pointer datapath. Assumes a 32-bit AXI4-Lite register bus.
*/
package dmac_pkg;
  // ********************************************************
  // Widths.
  // ********************************************************
  localparam int AW = 16;
  localparam int DW = 40;
  localparam int HW = 16;
  localparam int GW = 8;
  localparam int NREG = 8;
  localparam int RIW = 3;
  localparam int PIMM_W = 7;
  localparam int ABW = 8;
  localparam int BW = 32;
  localparam int BYTE = 8;
  // ********************************************************
  // Register map.
  // ********************************************************
  localparam logic [ABW-1:0] OFS_CMD = 8'h00;
  localparam logic [ABW-1:0] OFS_STAT = 8'h04;
  localparam logic [ABW-1:0] OFS_XMOD = 8'h08;
  localparam logic [ABW-1:0] OFS_YMOD = 8'h0c;
  localparam logic [ABW-1:0] OFS_PTR = 8'h20;
  localparam logic [ABW-1:0] OFS_STEP = 8'h40;
  localparam logic [ABW-1:0] OFS_ACC = 8'h80;
  localparam logic [ABW-1:0] GRP_MASK = 8'he0;
  localparam logic [ABW-1:0] ACC_MASK = 8'hc0;
  localparam int IDX_LO = 2;
  localparam int ACC_IDX_LO = 3;
  localparam int GUARD_BIT = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OV = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ********************************************************
  // Reset values and arithmetic constants.
  // ********************************************************
  localparam logic [DW-1:0] ACC_RST = 40'h0;
  localparam logic [AW-1:0] PTR_RST = 16'h0;
  localparam logic [AW-1:0] PTR_ONE = 16'h0001;
  localparam int SH_ONE = 1;
  localparam int SH_SIXTEEN = 16;
  // ********************************************************
  // Types.
  // ********************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_MAC = 5'h01, OP_MSB = 5'h02, OP_MSU = 5'h03,
    OP_MUU = 5'h04, OP_MH1 = 5'h05, OP_MH16 = 5'h06, OP_MUL = 5'h07,
    OP_ADD = 5'h08, OP_ADDI = 5'h09, OP_SUB = 5'h0a, OP_SUBI = 5'h0b,
    OP_SRA = 5'h0c, OP_SRAI = 5'h0d, OP_SRL = 5'h0e, OP_SRLI = 5'h0f,
    OP_SLL = 5'h10, OP_SLLI = 5'h11
  } dmac_op_t;
  typedef enum logic [2:0] {
    PM_PLAIN = 3'h0, PM_INC = 3'h1, PM_DEC = 3'h2, PM_STEP = 3'h3,
    PM_MOD = 3'h4, PM_BREV = 3'h5, PM_IMM = 3'h6
  } dmac_pmode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_MEM = 2'b10, ST_EXE = 2'b11
  } dmac_state_t;
  typedef struct packed {
    dmac_op_t op;
    logic [RIW-1:0] dst;
    logic [RIW-1:0] sa;
    logic [RIW-1:0] sb;
    logic mem_en;
    logic mem_wr;
    logic [RIW-1:0] psel;
    dmac_pmode_t pmode;
    logic [RIW-1:0] mreg;
    logic [PIMM_W-1:0] pimm;
  } dmac_instr_t;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic rd;
    logic wr;
    logic [HW-1:0] wdata;
  } dmac_mreq_t;
endpackage

// ### core/dmac_ptr_upd.sv
/*
  Address generation for one selected data pointer: access address and
  post-access value. Purely combinational; the caller holds the state.
*/
`timescale 1ns/10ps
module dmac_ptr_upd
  import dmac_pkg::*;
(
  // Selected pointer and its settings
  input wire logic [AW-1:0] ptr,
  input wire logic [AW-1:0] step,
  input wire logic [AW-1:0] modsz,
  input wire dmac_pmode_t mode,
  input wire logic [PIMM_W-1:0] pimm,
  // Access address and updated pointer
  output logic [AW-1:0] addr,
  output logic [AW-1:0] ptr_nxt
);
  logic [AW-1:0] mask;
  logic [AW-1:0] rev;
  logic [AW-1:0] modv;
  logic signed [AW+1:0] span;
  logic signed [AW+1:0] lsum;
  logic signed [AW+1:0] lwrap;
  genvar i;

  // RULE_23: ring span mask
  for (i = 0; i < AW; i++) begin : g_bit
    assign mask[i] = |(modsz >> i);
    assign rev[i] = ptr[AW-1-i];
  end

  // RULE_08: wrap low part
  assign span = {2'b00, modsz} + {{(AW+1){1'b0}}, 1'b1};
  assign lsum = $signed({2'b00, ptr & mask})
              + $signed({{2{step[AW-1]}}, step});
  assign lwrap = (lsum < 0) ? lsum + span
               : (lsum >= span) ? lsum - span : lsum;
  assign modv = (ptr & ~mask) | (lwrap[AW-1:0] & mask);

  // RULE_09: reversed address
  assign addr = (mode == PM_BREV) ? rev : ptr;

  // RULE_06: simple modes
  // RULE_07: step by same index
  always_comb begin
    case (mode)
      PM_INC: ptr_nxt = ptr + PTR_ONE;
      PM_DEC: ptr_nxt = ptr - PTR_ONE;
      PM_STEP: ptr_nxt = ptr + step;
      PM_BREV: ptr_nxt = ptr + step;
      PM_MOD: ptr_nxt = modv;
      PM_IMM: ptr_nxt = ptr + {{(AW-PIMM_W){pimm[PIMM_W-1]}}, pimm};
      default: ptr_nxt = ptr;
    endcase
  end
endmodule // dmac_ptr_upd

// ### core/dmac_core.sv
/*
  Fixed-point multiply-accumulate, add, subtract and shift datapath with
  eight 40-bit registers, eight data pointers and a sticky overflow flag,
  driven by instruction words written over AXI4-Lite.
  Assumes X and Y data memories that sample a request at a clock edge and
  return read data in the following cycle.
*/
`timescale 1ns/10ps
// Summary of operation
// RULE_01: Indirect access uses the selected pointer's value as address.
// RULE_02: Pointers 0-3 reach X memory, 4-7 reach Y memory.
// RULE_03: Pointer changes only after its access, which uses the old value.
// RULE_04: The next instruction already sees the updated pointer.
// RULE_05: Only an instruction accessing memory through a pointer modifies it.
// RULE_06: Plain keeps pointer; others add one, subtract one or an immediate.
// RULE_07: Step mode adds the step register with the pointer's index.
// RULE_08: Modulo mode wraps low part plus step by modulo plus one.
// RULE_09: Bit-reverse mode addresses the reversed pointer, then adds its step.
// RULE_10: Flag-affecting operations set overflow on overflow; others leave it.
// RULE_11: Overflow is sticky; operations without overflow never clear it.
// RULE_12: Unsigned form multiplies two low halves, accumulating into 40 bits.
// RULE_13: Signed-by-unsigned multiplies signed high half by unsigned low half.
// RULE_14: One form halves the accumulator first and updates overflow.
// RULE_15: Another form shifts the accumulator right 16, overflow untouched.
// RULE_16: Add and subtract on 40 bits, register or immediate, set overflow.
// RULE_17: Arithmetic right shift by low half or immediate, no overflow.
// RULE_18: Logical right shift fills zeros, no overflow.
// RULE_19: Logical left shift inserts zeros, no overflow.
// RULE_20: Only register forms pair with a memory load or store.
// RULE_21: Signed operands use bits 31-16; unsigned operands and amounts 15-0.
// RULE_22: Logical right shift fills zeros; arithmetic replicates the sign.
// RULE_23: Modulo low part lies below the smallest covering power of two.
module dmac_core
  import dmac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [ABW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // Write data channel
  input wire logic [BW-1:0] s_wdata,
  input wire logic [BW/BYTE-1:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response channel
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read address channel
  input wire logic [ABW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // Read data channel
  output logic [BW-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // X data memory
  output dmac_mreq_t x_req,
  input wire logic [HW-1:0] x_rdata,
  // Y data memory
  output dmac_mreq_t y_req,
  input wire logic [HW-1:0] y_rdata
);
  // ********************************************************
  // Declarations.
  // ********************************************************
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic arready_r;
  logic rvalid_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ABW-1:0] awaddr_r;
  logic [BW-1:0] wdata_r;
  logic [BW/BYTE-1:0] wstrb_r;
  logic [1:0] bresp_r;
  logic [1:0] rresp_r;
  logic [BW-1:0] rdata_r;
  logic [BW-1:0] rd_val;
  logic rd_err;
  logic [BW-1:0] wmask;
  logic [DW-1:0] acc_r [NREG];
  logic [DW-1:0] acc_nxt [NREG];
  logic [AW-1:0] ptr_r [NREG];
  logic [AW-1:0] ptr_nxt [NREG];
  logic [AW-1:0] step_r [NREG];
  logic [AW-1:0] step_nxt [NREG];
  logic [AW-1:0] xmod_r;
  logic [AW-1:0] ymod_r;
  logic ov_r;
  dmac_instr_t ins_r;
  dmac_state_t st_r;
  dmac_state_t st_nxt;
  dmac_mreq_t xreq_r;
  dmac_mreq_t yreq_r;
  dmac_mreq_t xreq_nxt;
  dmac_mreq_t yreq_nxt;
  logic [AW-1:0] pu_addr;
  logic [AW-1:0] pu_nxt;
  logic signed [DW:0] sum;
  logic ov_aff;
  logic res_en;
  genvar k;

  function automatic logic [BW-1:0] mrg(input logic [BW-1:0] o,
                                        input logic [BW-1:0] n,
                                        input logic [BW-1:0] m);
    return (o & ~m) | (n & m);
  endfunction

  // ********************************************************
  // AXI4-Lite handshakes.
  // ********************************************************
  wire aw_take = s_awvalid & awready_r;
  wire w_take = s_wvalid & wready_r;
  wire ar_take = s_arvalid & arready_r;
  wire wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
  wire aw_hold_nxt = aw_hold_r ? ~wr_do : aw_take;
  wire w_hold_nxt = w_hold_r ? ~wr_do : w_take;

  for (k = 0; k < BW / BYTE; k++) begin : g_lane
    assign wmask[k*BYTE +: BYTE] = {BYTE{wstrb_r[k]}};
  end

  // ********************************************************
  // Write decode.
  // ********************************************************
  wire busy = (st_r != ST_IDLE);
  wire w_cmd = (awaddr_r == OFS_CMD);
  wire w_stat = (awaddr_r == OFS_STAT);
  wire w_xmod = (awaddr_r == OFS_XMOD);
  wire w_ymod = (awaddr_r == OFS_YMOD);
  wire w_ptr = ((awaddr_r & GRP_MASK) == OFS_PTR);
  wire w_step = ((awaddr_r & GRP_MASK) == OFS_STEP);
  wire w_acc = ((awaddr_r & ACC_MASK) == OFS_ACC);
  wire [RIW-1:0] w_pidx = awaddr_r[IDX_LO +: RIW];
  wire [RIW-1:0] w_aidx = awaddr_r[ACC_IDX_LO +: RIW];
  wire w_guard = awaddr_r[GUARD_BIT];
  wire w_map = w_cmd | w_stat | w_xmod | w_ymod | w_ptr | w_step | w_acc;
  // Datapath state other than the overflow flag must not change under a running instruction.
  wire w_err = ~w_map | (busy & ~w_stat);
  wire sw_wr = wr_do & ~w_err;
  wire [BW-1:0] m16 = {{(BW-AW){1'b0}}, {AW{1'b1}}} & wmask;
  wire ov_clr = sw_wr & w_stat & wmask[STAT_OV] & wdata_r[STAT_OV];

  // ********************************************************
  // Read decode.
  // ********************************************************
  wire [RIW-1:0] r_pidx = s_araddr[IDX_LO +: RIW];
  wire [RIW-1:0] r_aidx = s_araddr[ACC_IDX_LO +: RIW];

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    if (s_araddr == OFS_CMD) begin
      rd_val = ins_r;
    end else if (s_araddr == OFS_STAT) begin
      rd_val[STAT_BUSY] = busy;
      rd_val[STAT_OV] = ov_r;
    end else if (s_araddr == OFS_XMOD) begin
      rd_val[AW-1:0] = xmod_r;
    end else if (s_araddr == OFS_YMOD) begin
      rd_val[AW-1:0] = ymod_r;
    end else if ((s_araddr & GRP_MASK) == OFS_PTR) begin
      rd_val[AW-1:0] = ptr_r[r_pidx];
    end else if ((s_araddr & GRP_MASK) == OFS_STEP) begin
      rd_val[AW-1:0] = step_r[r_pidx];
    end else if ((s_araddr & ACC_MASK) == OFS_ACC) begin
      if (s_araddr[GUARD_BIT]) begin
        rd_val[GW-1:0] = acc_r[r_aidx][DW-1:BW];
      end else begin
        rd_val = acc_r[r_aidx][BW-1:0];
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  // ********************************************************
  // Sequencer and pointer unit.
  // ********************************************************
  wire dmac_op_t op = ins_r.op;
  wire imm_op = (op == OP_ADDI) | (op == OP_SUBI) | (op == OP_SRAI)
              | (op == OP_SRLI) | (op == OP_SLLI);
  // RULE_20: immediate forms drop access
  wire mem_go = ins_r.mem_en & ~imm_op;
  // RULE_02: group from pointer index
  wire psel_y = ins_r.psel[RIW-1];
  wire in_exe = (st_r == ST_EXE);

  always_comb begin
    case (st_r)
      ST_IDLE: st_nxt = (sw_wr & w_cmd) ? ST_ISSUE : ST_IDLE;
      ST_ISSUE: st_nxt = ST_MEM;
      ST_MEM: st_nxt = ST_EXE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  dmac_ptr_upd u_ptr (
    .ptr(ptr_r[ins_r.psel]),
    .step(step_r[ins_r.psel]),
    .modsz(psel_y ? ymod_r : xmod_r),
    .mode(ins_r.pmode),
    .pimm(ins_r.pimm),
    .addr(pu_addr),
    .ptr_nxt(pu_nxt)
  );

  // RULE_01: pointer value is address
  wire req_on = (st_r == ST_ISSUE) & mem_go;
  wire [HW-1:0] st_data = acc_r[ins_r.mreg][HW-1:0];
  assign xreq_nxt = '{addr: pu_addr,
                      rd: req_on & ~psel_y & ~ins_r.mem_wr,
                      wr: req_on & ~psel_y & ins_r.mem_wr,
                      wdata: st_data};
  assign yreq_nxt = '{addr: pu_addr,
                      rd: req_on & psel_y & ~ins_r.mem_wr,
                      wr: req_on & psel_y & ins_r.mem_wr,
                      wdata: st_data};
  wire ld_en = in_exe & mem_go & ~ins_r.mem_wr;
  wire [HW-1:0] ld_data = psel_y ? y_rdata : x_rdata;

  // ********************************************************
  // Arithmetic.
  // ********************************************************
  wire [DW-1:0] ra = acc_r[ins_r.sa];
  wire [DW-1:0] rb = acc_r[ins_r.sb];
  wire [DW-1:0] rd0 = acc_r[ins_r.dst];
  wire [HW-1:0] imm = ins_r[HW-1:0];
  // RULE_21: operand halves
  wire signed [HW-1:0] ha = ra[HW +: HW];
  wire signed [HW-1:0] hb = rb[HW +: HW];
  wire [HW-1:0] la = ra[HW-1:0];
  wire [HW-1:0] lb = rb[HW-1:0];
  wire signed [2*HW-1:0] p_ss = ha * hb;
  // RULE_13: low half as positive
  wire signed [2*HW:0] p_su = ha * $signed({1'b0, lb});
  // RULE_12: both halves unsigned
  wire [2*HW-1:0] p_uu = la * lb;
  wire signed [DW:0] e_ss = {{(DW+1-2*HW){p_ss[2*HW-1]}}, p_ss};
  wire signed [DW:0] e_su = {{(DW-2*HW){p_su[2*HW]}}, p_su};
  wire signed [DW:0] e_uu = {{(DW+1-2*HW){1'b0}}, p_uu};
  wire signed [DW:0] e_i = {{(DW+1-HW){imm[HW-1]}}, imm};
  wire signed [DW:0] e_a = {ra[DW-1], ra};
  wire signed [DW:0] e_b = {rb[DW-1], rb};
  wire signed [DW:0] e_d = {rd0[DW-1], rd0};
  wire signed [DW-1:0] d_s = rd0;
  wire signed [DW-1:0] a_s = ra;
  // RULE_14: halve accumulator
  wire signed [DW:0] e_d1 = {d_s[DW-1], d_s >>> SH_ONE};
  // RULE_15: sixteen-bit shift
  wire signed [DW:0] e_d16 = {d_s[DW-1], d_s >>> SH_SIXTEEN};
  // RULE_17: amount from low half
  wire [HW-1:0] amt = imm_op ? imm : lb;
  // RULE_22: sign versus zero fill
  wire [DW-1:0] sra_v = a_s >>> amt;
  wire [DW-1:0] srl_v = ra >> amt;
  wire [DW-1:0] sll_v = ra << amt;

  // RULE_10: affecting forms marked
  always_comb begin
    sum = e_d + e_ss;
    ov_aff = 1'b0;
    res_en = 1'b1;
    case (op)
      OP_MAC: ov_aff = 1'b1;
      OP_MSB: begin
        sum = e_d - e_ss;
        ov_aff = 1'b1;
      end
      OP_MSU: begin
        sum = e_d + e_su;
        ov_aff = 1'b1;
      end
      OP_MUU: begin
        sum = e_d + e_uu;
        ov_aff = 1'b1;
      end
      OP_MH1: begin
        sum = e_d1 + e_ss;
        ov_aff = 1'b1;
      end
      OP_MH16: sum = e_d16 + e_ss;
      OP_MUL: sum = e_ss;
      // RULE_16: forty-bit add and subtract
      OP_ADD: begin
        sum = e_a + e_b;
        ov_aff = 1'b1;
      end
      OP_ADDI: begin
        sum = e_a + e_i;
        ov_aff = 1'b1;
      end
      OP_SUB: begin
        sum = e_a - e_b;
        ov_aff = 1'b1;
      end
      OP_SUBI: begin
        sum = e_a - e_i;
        ov_aff = 1'b1;
      end
      OP_SRA: sum = {1'b0, sra_v};
      OP_SRAI: sum = {1'b0, sra_v};
      // RULE_18: zero-filled right shift
      OP_SRL: sum = {1'b0, srl_v};
      OP_SRLI: sum = {1'b0, srl_v};
      // RULE_19: zero-filled left shift
      OP_SLL: sum = {1'b0, sll_v};
      OP_SLLI: sum = {1'b0, sll_v};
      default: begin
        sum = '0;
        res_en = 1'b0;
      end
    endcase
  end

  wire [DW-1:0] res = sum[DW-1:0];
  wire ov_set = in_exe & ov_aff & (sum[DW] ^ sum[DW-1]);
  // RULE_11: set wins, never auto-cleared
  wire ov_nxt = ov_set | (ov_r & ~ov_clr);

  // ********************************************************
  // Register next values.
  // ********************************************************
  for (k = 0; k < NREG; k++) begin : g_reg
    wire ex_k = in_exe & res_en & (ins_r.dst == RIW'(k));
    wire ld_k = ld_en & (ins_r.mreg == RIW'(k));
    wire sw_a = sw_wr & w_acc & (w_aidx == RIW'(k));
    wire sw_p = sw_wr & w_ptr & (w_pidx == RIW'(k));
    wire sw_s = sw_wr & w_step & (w_pidx == RIW'(k));
    // RULE_03: modify after access
    // RULE_05: only with an access
    wire up_p = in_exe & mem_go & (ins_r.psel == RIW'(k));
    wire [BW-1:0] lo_m = mrg(acc_r[k][BW-1:0], wdata_r, wmask);
    wire [BW-1:0] hi_m = mrg({{(BW-GW){1'b0}}, acc_r[k][DW-1:BW]},
                             wdata_r, wmask);
    wire [DW-1:0] a1 = ex_k ? res : acc_r[k];
    // A load in the same instruction lands after the arithmetic result.
    assign acc_nxt[k] = (sw_a & ~w_guard) ? {acc_r[k][DW-1:BW], lo_m}
                      : (sw_a & w_guard) ? {hi_m[GW-1:0], acc_r[k][BW-1:0]}
                      : ld_k ? {a1[DW-1:HW], ld_data} : a1;
    wire [BW-1:0] p_m = mrg({{(BW-AW){1'b0}}, ptr_r[k]}, wdata_r, m16);
    wire [BW-1:0] s_m = mrg({{(BW-AW){1'b0}}, step_r[k]}, wdata_r, m16);
    // RULE_04: ready for next instruction
    assign ptr_nxt[k] = sw_p ? p_m[AW-1:0] : up_p ? pu_nxt : ptr_r[k];
    assign step_nxt[k] = sw_s ? s_m[AW-1:0] : step_r[k];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc_r[k] <= ACC_RST;
        ptr_r[k] <= PTR_RST;
        step_r[k] <= PTR_RST;
      end else begin
        acc_r[k] <= acc_nxt[k];
        ptr_r[k] <= ptr_nxt[k];
        step_r[k] <= step_nxt[k];
      end
    end
  end

  wire [BW-1:0] xm_m = mrg({{(BW-AW){1'b0}}, xmod_r}, wdata_r, m16);
  wire [BW-1:0] ym_m = mrg({{(BW-AW){1'b0}}, ymod_r}, wdata_r, m16);
  wire [BW-1:0] ins_m = mrg(ins_r, wdata_r, wmask);

  // ********************************************************
  // Flip-flops.
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      ins_r <= '0;
      ov_r <= 1'b0;
      xmod_r <= PTR_RST;
      ymod_r <= PTR_RST;
      xreq_r <= '0;
      yreq_r <= '0;
    end else begin
      st_r <= st_nxt;
      ins_r <= (sw_wr & w_cmd) ? dmac_instr_t'(ins_m) : ins_r;
      ov_r <= ov_nxt;
      xmod_r <= (sw_wr & w_xmod) ? xm_m[AW-1:0] : xmod_r;
      ymod_r <= (sw_wr & w_ymod) ? ym_m[AW-1:0] : ymod_r;
      xreq_r <= xreq_nxt;
      yreq_r <= yreq_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt;
      wready_r <= ~w_hold_nxt;
      awaddr_r <= aw_take ? s_awaddr : awaddr_r;
      wdata_r <= w_take ? s_wdata : wdata_r;
      wstrb_r <= w_take ? s_wstrb : wstrb_r;
      bvalid_r <= wr_do | (bvalid_r & ~s_bready);
      bresp_r <= wr_do ? (w_err ? RESP_SLVERR : RESP_OKAY) : bresp_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= rvalid_r ? s_rready : ~ar_take;
      rvalid_r <= ar_take | (rvalid_r & ~s_rready);
      rdata_r <= ar_take ? rd_val : rdata_r;
      rresp_r <= ar_take ? (rd_err ? RESP_SLVERR : RESP_OKAY) : rresp_r;
    end
  end

  assign s_awready = awready_r;
  assign s_wready = wready_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = arready_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;
  assign x_req = xreq_r;
  assign y_req = yreq_r;
endmodule // dmac_core

// ### sim/dmac_core_checker.sv
/*
  Port checker for the datapath core, bound to dmac_core.
  Assumes the single clock aclk and the synchronous low reset aresetn.
*/
`timescale 1ns/10ps
module dmac_core_checker
  import dmac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [BW-1:0] s_rdata,
  // Data memories
  input wire dmac_mreq_t x_req,
  input wire dmac_mreq_t y_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_awvalid && s_awready && s_wvalid
    && s_wready |=> ##1 s_bvalid) else $error("write answer late");
  a_aw_blocked: assert property (s_awvalid && s_awready |=> !s_awready)
    else $error("address taken twice");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid
    && !s_arready) else $error("read answer late");
  a_rdata_stands: assert property (s_rvalid && !s_rready |=> s_rvalid
    && $stable(s_rdata)) else $error("read data dropped");
  a_xy_exclusive: assert property (!((x_req.rd || x_req.wr) &&
    (y_req.rd || y_req.wr))) else $error("both memories accessed");
  a_x_single: assert property ((x_req.rd || x_req.wr) |=>
    !(x_req.rd || x_req.wr)) else $error("x access repeated");
  a_y_single: assert property ((y_req.rd || y_req.wr) |=>
    !(y_req.rd || y_req.wr)) else $error("y access repeated");
  a_access_cause: assert property ((x_req.rd || x_req.wr ||
    y_req.rd || y_req.wr) |-> $past(s_bvalid))
    else $error("access without instruction");
endmodule // dmac_core_checker

bind dmac_core dmac_core_checker dmac_core_checker_i (.*);

// ### sim/dmac_mem_model.sv
/*
  Behavioural 64K x 16 data memory seen by one pointer group.
  Assumes requests are sampled at the rising edge of aclk.
*/
`timescale 1ns/10ps
module dmac_mem_model
  import dmac_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Request and read data
  input wire dmac_mreq_t req,
  output logic [HW-1:0] rdata
);
  logic [HW-1:0] mem [2**AW];
  initial begin
    rdata = '0;
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = i[HW-1:0] ^ 16'h5a5a;
    end
  end
  // Data is valid one cycle only; later it toggles so stale use shows.
  always @(posedge aclk) begin
    if (req.wr) mem[req.addr] <= req.wdata;
    if (req.rd) rdata <= mem[req.addr];
    else rdata <= ~rdata;
  end
endmodule // dmac_mem_model

// ### sim/testbench.sv
/*
  Self-checking bench: AXI4-Lite tasks and instruction tables.
  Assumes one memory model on each of the X and Y request ports.
*/
`timescale 1ns/10ps
module testbench;
  import dmac_pkg::*;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [ABW-1:0] s_awaddr, s_araddr;
  logic [BW-1:0] s_wdata, s_rdata, v;
  logic [1:0] s_bresp, s_rresp, r;
  logic [3:0] s_wstrb;
  logic [39:0] q;
  dmac_mreq_t x_req, y_req;
  logic [HW-1:0] x_rdata, y_rdata;
  int fail_count, comparisons, n;
  localparam logic [39:0] EXP [18] = '{40'h100, 40'h106, 40'hfa,
    40'h115, 40'h123, 40'h86, 40'h6, 40'h6, 40'h800005000c,
    40'h8000030003, 40'h800000fffe, 40'h8000030007, 40'hff00000600,
    40'hf800003000, 40'h0100000600, 40'h0800003000, 40'h0001800280,
    40'h0000300050};
  localparam logic [15:0] PEXP [7] = '{16'h106, 16'h107, 16'h105,
    16'h109, 16'h101, 16'h109, 16'h104};
  dmac_core dmac_core_i (.*);
  dmac_mem_model dmac_mem_model_x_i (.aclk(aclk), .req(x_req),
    .rdata(x_rdata));
  dmac_mem_model dmac_mem_model_y_i (.aclk(aclk), .req(y_req),
    .rdata(y_rdata));
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A stuck handshake ends the run here rather than hanging.
  task automatic tick();
    @(posedge aclk);
    n++;
    if (n > 100) begin
      fail_count++;
      $display("[ERR] %0t bus timeout", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(ah && wh)) begin
      tick();
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      ah = ah | s_awready;
      wh = wh | s_wready;
    end
    s_bready <= 1'b1;
    while (!s_bvalid) tick();
    r = s_bresp;
    s_bready <= 1'b0;
  endtask
  // Ready is raised late on purpose so the answer must stand.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do tick(); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) tick();
    s_rready <= 1'b1;
    tick();
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic wracc(input logic [2:0] k, input logic [39:0] d);
    wr(OFS_ACC + {2'b00, k, 3'b000}, d[31:0]);
    wr(OFS_ACC + {2'b00, k, 3'b100}, {24'h0, d[39:32]});
  endtask
  task automatic rdacc(input logic [2:0] k);
    logic [31:0] lo;
    rd(OFS_ACC + {2'b00, k, 3'b000}, lo);
    rd(OFS_ACC + {2'b00, k, 3'b100}, v);
    q = {v[7:0], lo};
  endtask
  task automatic issue(input logic [31:0] w);
    wr(OFS_CMD, w);
    v = 32'h1;
    for (int i = 0; i < 4 && v[0]; i++) rd(OFS_STAT, v);
    check(v[0], 1'b0);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hf;
    fail_count = 0;
    comparisons = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_STAT, v);
    check(v, 40'h0);
    rdacc(3'h0);
    check(q, ACC_RST);
    wr(OFS_ACC + 8'h08, 32'h1234);
    issue({OP_NOP, 9'h0, 2'b11, 3'h1, PM_INC, 3'h1, 7'h0});
    issue({OP_NOP, 9'h0, 2'b10, 3'h1, PM_DEC, 3'h2, 7'h0});
    rdacc(3'h2);
    check(q, 40'h5a5b);
    issue({OP_NOP, 9'h0, 2'b10, 3'h1, PM_PLAIN, 3'h2, 7'h0});
    rdacc(3'h2);
    check(q, 40'h1234);
    wr(OFS_YMOD, 32'h7);
    for (int m = 0; m < 7; m++) begin
      wr(OFS_PTR + 8'h10, 32'h106);
      wr(OFS_STEP + 8'h10, 32'h3);
      issue({OP_NOP, 9'h0, 2'b10, 3'h4, 3'(m), 3'h3, 7'h7e});
      rd(OFS_PTR + 8'h10, v);
      check(v, PEXP[m]);
      rdacc(3'h3);
      check(q, (m == 5 ? 16'h6080 : 16'h106) ^ 16'h5a5a);
    end
    wracc(3'h0, 40'h8000030005);
    wracc(3'h1, 40'h0000020007);
    for (int k = 0; k < 18; k++) begin
      wracc(3'h2, 40'h100);
      issue({5'(k), 9'o201, 2'b00, (k == 13 || k == 15 || k == 17) ?
        16'h0004 : 16'hfffe});
      rdacc(3'h2);
      check(q, EXP[k]);
    end
    issue({OP_ADDI, 9'o200, 2'b10, 16'he400});
    rd(OFS_PTR + 8'h1c, v);
    check(v, 40'h0);
    rd(OFS_STAT, v);
    check(v, 40'h0);
    issue({OP_ADD, 9'o200, 18'h0});
    rd(OFS_STAT, v);
    check(v, 40'h2);
    issue({OP_ADD, 9'o211, 18'h0});
    issue({OP_MH16, 9'o201, 18'h0});
    rd(OFS_STAT, v);
    check(v, 40'h2);
    wr(OFS_STAT, 32'h2);
    rd(OFS_STAT, v);
    check(v, 40'h0);
    wr(8'h10, 32'h1);
    check(r, RESP_SLVERR);
    rd(8'hfc, v);
    check({r, v}, {RESP_SLVERR, 32'h0});
    finish_test();
  end
endmodule // testbench
